// ==== rtl/pifp_consts.svh ====
// register offsets, bit positions and reset values of the irq flag pairs
// assumes nothing; definitions only
`ifndef PIFP_CONSTS_SVH
`define PIFP_CONSTS_SVH

// ****************************************************************
// register addresses in the cpu data space
// ****************************************************************
`define PIFP_ADDR_INTERVAL 12'hfb8
`define PIFP_ADDR_MATCH_B 12'hfbb
`define PIFP_ADDR_MATCH_A 12'hfbc
`define PIFP_ADDR_KEY_PORT 12'hfbd

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define PIFP_EN_BIT 1
`define PIFP_REQ_BIT 0
`define PIFP_EN_RST 1'b0
`define PIFP_REQ_RST 1'b0
`define PIFP_SRC_COUNT 4

`endif

// ==== rtl/pifp_pkg.sv ====
// types shared by the irq flag pair modules
// assumes the constants header is compiled alongside
package pifp_pkg;

    // source index, ordered by register address
    typedef enum logic [1:0] {
        PIFP_SRC_INTERVAL = 2'h0,
        PIFP_SRC_MATCH_B = 2'h1,
        PIFP_SRC_MATCH_A = 2'h2,
        PIFP_SRC_KEY_PORT = 2'h3
    } pifp_src_e;

    typedef logic [3:0] pifp_nib_t;

endpackage

// ==== rtl/pifp_flag_if.sv ====
// carrier between the top and one enable/request flag pair
// assumes the top drives the strobes synchronous to the system clock
`timescale 1ns/1ps

interface pifp_flag_if;
    import pifp_pkg::*;
    logic event_p;
    logic ack_p;
    logic wr_p;
    logic bit_mode;
    logic [1:0] bit_sel;
    pifp_nib_t wdata;
    logic enable;
    logic request;

    modport flag (
        input event_p, ack_p, wr_p, bit_mode, bit_sel, wdata,
        output enable, request
    );
    modport ctrl (
        output event_p, ack_p, wr_p, bit_mode, bit_sel, wdata,
        input enable, request
    );
endinterface

// ==== rtl/pifp_flag_pair.sv ====
// one enable/request flag pair of a peripheral interrupt source
// assumes strobes are one-cycle pulses on sys_clk_i
`timescale 1ns/1ps
`include "pifp_consts.svh"

module pifp_flag_pair
    import pifp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    pifp_flag_if.flag fl
);

    logic en_q, en_d;
    logic req_q, req_d;

    // ****************************************************************
    // next state: write, then service clear, then source event
    // ****************************************************************
    always_comb begin
        en_d = en_q;
        req_d = req_q;
        if (fl.wr_p) begin
            if (fl.bit_mode) begin
                // single-bit access; bits 3-2 are not stored
                if (fl.bit_sel == 2'(`PIFP_EN_BIT)) begin
                    en_d = fl.wdata[0];
                end
                if (fl.bit_sel == 2'(`PIFP_REQ_BIT)) begin
                    req_d = fl.wdata[0];
                end
            end else begin
                en_d = fl.wdata[`PIFP_EN_BIT];
                req_d = fl.wdata[`PIFP_REQ_BIT];
            end
        end
        if (fl.ack_p) begin
            req_d = 1'b0;
        end
        // last so a source event never gets lost to a clear
        if (fl.event_p) begin
            req_d = 1'b1;
        end
    end

    // flag registers; both clear at reset
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_q <= `PIFP_EN_RST;
            req_q <= `PIFP_REQ_RST;
        end else begin
            en_q <= en_d;
            req_q <= req_d;
        end
    end

    assign fl.enable = en_q;
    assign fl.request = req_q;

endmodule

// ==== rtl/pifp_top.sv ====
// four peripheral interrupt enable/request flag registers on the cpu data bus
// assumes cpu strobes and source pulses are synchronous one-cycle pulses
`timescale 1ns/1ps
`include "pifp_consts.svh"

module pifp_top
    import pifp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [11:0] cpu_addr_i,
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    input wire logic cpu_bit_mode_i,
    input wire logic [1:0] cpu_bit_sel_i,
    input wire logic [3:0] cpu_wdata_i,
    output logic [3:0] cpu_rdata_o,
    output logic cpu_rvalid_o,
    input wire logic interval_tick_i,
    input wire logic match_a_i,
    input wire logic match_b_i,
    input wire logic key_edge_i,
    input wire logic ack_i,
    input wire logic [1:0] ack_src_i,
    output logic [3:0] irq_pending_o
);

    // ****************************************************************
    // address decode
    // ****************************************************************
    // returns {hit, source index}; shared by write and read paths
    function automatic logic [2:0] decode_addr(input logic [11:0] addr);
        logic [2:0] r;
        r = 3'h0;
        case (addr)
            `PIFP_ADDR_INTERVAL: r = {1'b1, PIFP_SRC_INTERVAL};
            `PIFP_ADDR_MATCH_B: r = {1'b1, PIFP_SRC_MATCH_B};
            `PIFP_ADDR_MATCH_A: r = {1'b1, PIFP_SRC_MATCH_A};
            `PIFP_ADDR_KEY_PORT: r = {1'b1, PIFP_SRC_KEY_PORT};
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    logic [2:0] dec;
    logic [3:0] ev;
    logic [3:0] req_w;
    logic [3:0] en_w;

    assign dec = decode_addr(cpu_addr_i);
    // source pulses in register order
    assign ev = {key_edge_i, match_a_i, match_b_i, interval_tick_i};

    // ****************************************************************
    // flag pairs
    // ****************************************************************
    pifp_flag_if fl[`PIFP_SRC_COUNT] ();

    for (genvar g = 0; g < `PIFP_SRC_COUNT; g++) begin : g_src
        // each source sees only its own write and acknowledge
        assign fl[g].event_p = ev[g];
        assign fl[g].ack_p = ack_i && (ack_src_i == 2'(g));
        assign fl[g].wr_p = cpu_wr_i && dec[2] && (dec[1:0] == 2'(g));
        assign fl[g].bit_mode = cpu_bit_mode_i;
        assign fl[g].bit_sel = cpu_bit_sel_i;
        assign fl[g].wdata = cpu_wdata_i;
        assign req_w[g] = fl[g].request;
        assign en_w[g] = fl[g].enable;

        pifp_flag_pair u_pair (
            .sys_clk_i(sys_clk_i),
            .nrst_i(nrst_i),
            .fl(fl[g])
        );
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    logic [3:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    // unmapped addresses read zero; upper bits always zero
    always_comb begin
        logic [3:0] word;
        word = 4'h0;
        if (dec[2]) begin
            word = {2'b00, en_w[dec[1:0]], req_w[dec[1:0]]};
        end
        rdata_d = 4'h0;
        if (cpu_rd_i) begin
            if (cpu_bit_mode_i) begin
                rdata_d = {3'b000, word[cpu_bit_sel_i]};
            end else begin
                rdata_d = word;
            end
        end
        rvalid_d = cpu_rd_i;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 4'h0;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign cpu_rdata_o = rdata_q;
    assign cpu_rvalid_o = rvalid_q;

    // ****************************************************************
    // interrupt presentation
    // ****************************************************************
    logic [3:0] pend_q, pend_d;

    // registered one cycle behind the flags so the output is glitch free
    always_comb begin
        pend_d = req_w & en_w;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_q <= 4'h0;
        end else begin
            pend_q <= pend_d;
        end
    end

    assign irq_pending_o = pend_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    property p_interval_set;
        interval_tick_i |=> req_w[0] ##1 (req_w[0] || $past(ack_i) || $past(cpu_wr_i));
    endproperty
    a_interval_set: assert property (p_interval_set)
        else $error("interval request not set by tick");

    property p_match_a_set;
        match_a_i |=> req_w[2];
    endproperty
    a_match_a_set: assert property (p_match_a_set)
        else $error("match a request not set by match");

    property p_match_a_clr;
        (ack_i && ack_src_i == 2'h2 && !match_a_i) |=> !req_w[2] && !pend_d[2];
    endproperty
    a_match_a_clr: assert property (p_match_a_clr)
        else $error("match a request not cleared on service");

    property p_match_b_clr;
        (ack_i && ack_src_i == 2'h1 && !match_b_i) |=> !req_w[1] ##1 !irq_pending_o[1];
    endproperty
    a_match_b_clr: assert property (p_match_b_clr)
        else $error("match b request not cleared on acknowledge");

    property p_key_set;
        key_edge_i |=> req_w[3];
    endproperty
    a_key_set: assert property (p_key_set)
        else $error("key port request not set by edge");

    property p_upper_zero;
        cpu_rvalid_o |-> cpu_rdata_o[3:2] == 2'b00;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper flag bits read nonzero");

    property p_match_a_write;
        (cpu_wr_i && !cpu_bit_mode_i && cpu_addr_i == `PIFP_ADDR_MATCH_A)
            |=> en_w[2] == $past(cpu_wdata_i[1]);
    endproperty
    a_match_a_write: assert property (p_match_a_write)
        else $error("match a enable not written from bit 1");

    property p_pending;
        ##1 irq_pending_o == ($past(req_w) & $past(en_w));
    endproperty
    a_pending: assert property (p_pending)
        else $error("pending output not request and enable");

    // remaining set and service paths, so every source has both directions watched
    property p_match_b_set;
        match_b_i |=> req_w[1];
    endproperty
    a_match_b_set: assert property (p_match_b_set)
        else $error("match b request not set by match");

    property p_interval_clr;
        (ack_i && ack_src_i == 2'h0 && !interval_tick_i) |=> !req_w[0];
    endproperty
    a_interval_clr: assert property (p_interval_clr)
        else $error("interval request not cleared on service");

    property p_key_clr;
        (ack_i && ack_src_i == 2'h3 && !key_edge_i) |=> !req_w[3];
    endproperty
    a_key_clr: assert property (p_key_clr)
        else $error("key port request not cleared on service");

    // a fully masked block must stay silent whatever the requests do
    property p_masked_quiet;
        (en_w == 4'h0) |=> irq_pending_o == 4'h0;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("pending output raised while all sources masked");

endmodule

// ==== verif/pifp_svc_model.sv ====
// cpu-side service model: acknowledges pending irqs, lowest index first
// assumes the pending bits are registered on the same clock
`timescale 1ns/1ps

// ********
// service model
// ********
module pifp_svc_model (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic [1:0] dly_i,
    input wire logic [3:0] pend_i,
    output logic ack_o,
    output logic [1:0] src_o
);
    // lowest pending index wins, as a fixed-priority sequencer would
    function automatic logic [1:0] first_set(input logic [3:0] p);
        first_set = 2'h0;
        for (int k = 3; k >= 0; k--) begin
            if (p[k]) begin
                first_set = 2'(k);
            end
        end
    endfunction

    // key pins taken as already set up as interrupt inputs
    // idle after each ack until the clear has reached the pending output
    initial begin
        ack_o = 1'b0;
        src_o = 2'h0;
        forever begin
            @(posedge sys_clk_i);
            #1;
            if (en_i && nrst_i && (pend_i != 4'h0)) begin
                // keep every change at the same small offset after the edge
                repeat (dly_i) begin
                    @(posedge sys_clk_i);
                    #1;
                end
                src_o = first_set(pend_i);
                ack_o = 1'b1;
                @(posedge sys_clk_i);
                #1;
                ack_o = 1'b0;
                src_o = ~src_o; // released select shows no stale value
                repeat (2) @(posedge sys_clk_i);
            end
        end
    end
endmodule

// ==== verif/peripheral_irq_flag_pairs_tb.sv ====
// self-checking bench for the four irq flag pair registers
// assumes a service model acknowledges pending sources when enabled
`timescale 1ns/1ps
`include "pifp_consts.svh"

module peripheral_irq_flag_pairs_tb;
    import pifp_pkg::*;
    logic sys_clk_i;
    logic nrst_i;
    logic [11:0] cpu_addr_i;
    logic cpu_wr_i, cpu_rd_i, cpu_bit_mode_i, cpu_rvalid_o, ack_i, svc_en, seen;
    logic [1:0] cpu_bit_sel_i, ack_src_i, dly, v;
    logic [3:0] cpu_wdata_i, cpu_rdata_o, ev, irq_pending_o;
    logic [11:0] addr_tab [4];
    int err_count, checked;

    pifp_top dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cpu_addr_i(cpu_addr_i),
        .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_bit_mode_i(cpu_bit_mode_i),
        .cpu_bit_sel_i(cpu_bit_sel_i), .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o),
        .cpu_rvalid_o(cpu_rvalid_o), .interval_tick_i(ev[0]), .match_b_i(ev[1]),
        .match_a_i(ev[2]), .key_edge_i(ev[3]), .ack_i(ack_i), .ack_src_i(ack_src_i),
        .irq_pending_o(irq_pending_o));
    pifp_svc_model svc (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .en_i(svc_en),
        .dly_i(dly), .pend_i(irq_pending_o), .ack_o(ack_i), .src_o(ack_src_i));

    // ********
    // helpers
    // ********
    // upper two bits always read back as zero
    function automatic logic [3:0] exp_nib(input logic en, input logic req);
        exp_nib = {2'b00, en, req};
    endfunction

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic bm, input logic [1:0] s,
                      input logic [3:0] d);
        @(posedge sys_clk_i);
        #1;
        cpu_addr_i = a;
        cpu_bit_mode_i = bm;
        cpu_bit_sel_i = s;
        cpu_wdata_i = d;
        cpu_wr_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        cpu_wr_i = 1'b0;
    endtask

    // read data stands one cycle, so it is sampled right after its edge
    task automatic rd_chk(input logic [11:0] a, input logic bm, input logic [1:0] s,
                          input logic [3:0] exp);
        @(posedge sys_clk_i);
        #1;
        cpu_addr_i = a;
        cpu_bit_mode_i = bm;
        cpu_bit_sel_i = s;
        cpu_rd_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        cpu_rd_i = 1'b0;
        chk({3'h0, cpu_rvalid_o}, 4'h1);
        chk(cpu_rdata_o, exp);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ********
    // clock and watchdog
    // ********
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // whole run is a few hundred cycles; this span leaves wide margin
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        err_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // ********
    // tests
    // ********
    initial begin
        addr_tab = '{`PIFP_ADDR_INTERVAL, `PIFP_ADDR_MATCH_B, `PIFP_ADDR_MATCH_A,
                     `PIFP_ADDR_KEY_PORT};
        {nrst_i, cpu_wr_i, cpu_rd_i, cpu_bit_mode_i, svc_en, seen} = '0;
        {cpu_addr_i, cpu_bit_sel_i, cpu_wdata_i, ev, v} = '0;
        dly = 2'($urandom(44258));
        err_count = 0;
        checked = 0;
        repeat (16) @(posedge sys_clk_i);
        #1;
        nrst_i = 1'b1;
        // reset values, and an unmapped place between the registers
        for (int i = 0; i < 4; i++) begin
            rd_chk(addr_tab[i], 1'b0, 2'h0, exp_nib(1'b0, 1'b0));
        end
        rd_chk(12'h0fb9, 1'b0, 2'h0, 4'h0);
        $display("test reset values done");
        // nibble writes with upper bits set, then single-bit writes and reads
        for (int i = 0; i < 4; i++) begin
            v = 2'($urandom);
            wr(addr_tab[i], 1'b0, 2'h0, {2'b11, v});
            rd_chk(addr_tab[i], 1'b0, 2'h0, exp_nib(v[1], v[0]));
            wr(addr_tab[i], 1'b1, 2'h1, {3'h0, ~v[1]});
            rd_chk(addr_tab[i], 1'b1, 2'h1, {3'h0, ~v[1]});
            rd_chk(addr_tab[i], 1'b1, 2'h3, 4'h0);
            rd_chk(addr_tab[i], 1'b0, 2'h0, exp_nib(~v[1], v[0]));
            wr(addr_tab[i], 1'b0, 2'h0, 4'h0);
        end
        $display("test register access done");
        // each source: set while masked, unmask, serviced at a random delay
        for (int i = 0; i < 4; i++) begin
            dly = 2'($urandom);
            @(posedge sys_clk_i);
            #1;
            ev[i] = 1'b1;
            @(posedge sys_clk_i);
            #1;
            ev = 4'h0;
            rd_chk(addr_tab[i], 1'b0, 2'h0, exp_nib(1'b0, 1'b1));
            chk(irq_pending_o, 4'h0);
            svc_en = 1'b1;
            wr(addr_tab[i], 1'b1, 2'h1, 4'h1);
            seen = 1'b0;
            for (int k = 0; k < 8 && !seen; k++) begin
                @(posedge sys_clk_i);
                #1;
                seen = (irq_pending_o[i] === 1'b1);
            end
            chk({3'h0, seen}, 4'h1);
            for (int k = 0; k < 12 && irq_pending_o !== 4'h0; k++) begin
                @(posedge sys_clk_i);
                #1;
            end
            chk(irq_pending_o, 4'h0);
            svc_en = 1'b0;
            rd_chk(addr_tab[i], 1'b0, 2'h0, exp_nib(1'b1, 1'b0));
            wr(addr_tab[i], 1'b0, 2'h0, 4'h0);
        end
        $display("test source service done");
        // corner: source event and a single-bit request clear in one cycle, the set wins
        @(posedge sys_clk_i);
        #1;
        {cpu_addr_i, cpu_bit_mode_i, cpu_bit_sel_i, cpu_wdata_i} =
            {`PIFP_ADDR_MATCH_A, 1'b1, 2'h0, 4'h0};
        cpu_wr_i = 1'b1;
        ev[2] = 1'b1;
        @(posedge sys_clk_i);
        #1;
        cpu_wr_i = 1'b0;
        ev = 4'h0;
        rd_chk(`PIFP_ADDR_MATCH_A, 1'b1, 2'h0, 4'h1);
        // single-bit write of the request bit alone clears it
        wr(`PIFP_ADDR_MATCH_A, 1'b1, 2'h0, 4'h0);
        rd_chk(`PIFP_ADDR_MATCH_A, 1'b1, 2'h0, 4'h0);
        $display("test corner cases done");
        report_and_stop();
    end
endmodule
